// File: dioe_pkg.sv
// Shared constants and types for the digital I/O edge timestamp block
package dioe_pkg;
    // ------------------------------------------------------------
    // Channel and FIFO geometry
    // ------------------------------------------------------------
    localparam int NCH = 61;
    localparam int NOUT = 42;
    localparam int LOW_W = 32;
    localparam int HIGH_W = 10;
    localparam int F2_W = 29;
    localparam int NGRP = 6;
    localparam int GRP_SZ = 8;
    localparam int NFIFO = 2;
    localparam int FIFO_DEPTH = 511;
    localparam int CNT_W = 9;
    localparam int ENT_W = 64;
    localparam int ADDR_W = 8;

    // ------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_DIR = 8'h00;
    localparam logic [7:0] ADDR_LOW_SET = 8'h04;
    localparam logic [7:0] ADDR_LOW_CLR = 8'h08;
    localparam logic [7:0] ADDR_LOW_RB = 8'h0C;
    localparam logic [7:0] ADDR_HIGH_SET = 8'h10;
    localparam logic [7:0] ADDR_HIGH_CLR = 8'h14;
    localparam logic [7:0] ADDR_HIGH_RB = 8'h18;
    localparam logic [7:0] ADDR_CMD = 8'h1C;
    // FIFO windows: paddr[7:5] picks the window, paddr[4:2] the word
    localparam logic [2:0] WIN_FIFO1 = 3'h1;
    localparam logic [2:0] WIN_FIFO2 = 3'h2;
    localparam logic [2:0] W_MON = 3'h0;
    localparam logic [2:0] W_FILL = 3'h1;
    localparam logic [2:0] W_POP_LVL = 3'h2;
    localparam logic [2:0] W_POP_STAMP = 3'h3;
    localparam logic [2:0] W_TIMER = 3'h4;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int FILT_BIT = 8;
    localparam int CMD_CLR1 = 0;
    localparam int CMD_CLR2 = 1;
    localparam int CMD_SYNC = 2;
    localparam logic [5:0] DIR_RST = 6'h00;
    localparam logic [41:0] OUT_RST = 42'h000_0000_0000;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 100;
    localparam int CLK_NS = 1000 / CLK_MHZ;
    localparam int FILT_NS = 20;
    localparam int FILT_CYC = FILT_NS / CLK_NS;

    // Register bus handshake states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_ACK = 2'b10
    } dioe_apb_st_t;
endpackage

// File: dioe_fifo_if.sv
// Push/pop carrier between the block and one edge FIFO
interface dioe_fifo_if #(parameter int W = 64, parameter int CW = 9);
    logic push;
    logic pop;
    logic clear;
    logic [W-1:0] wdata;
    logic [W-1:0] rdata;
    logic [CW-1:0] count;
    logic full;
    logic empty;
    modport store (input push, input pop, input clear, input wdata,
        output rdata, output count, output full, output empty);
    modport user (output push, output pop, output clear, output wdata,
        input rdata, input count, input full, input empty);
endinterface

// File: dioe_sync.sv
// Two-flop synchroniser for pin inputs
module dioe_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Data
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta;

    // First stage feeds only the second
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            meta <= '0;
            q_o <= '0;
        end else begin
            meta <= d_i;
            q_o <= meta;
        end
    end
endmodule

// File: dioe_fifo.sv
// Entry-pair FIFO with fill count, drop on full, clear
module dioe_fifo #(
    parameter int DEPTH = dioe_pkg::FIFO_DEPTH,
    parameter int W = dioe_pkg::ENT_W
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Push/pop side
    dioe_fifo_if.store fi
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    logic [W-1:0] mem [DEPTH];
    logic [PW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
    logic [CW-1:0] cnt, next_cnt;
    logic do_push, do_pop;

    function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
        return (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    // Pointer and count update; clear wins, full drops the push
    always_comb begin
        do_push = fi.push & (cnt != CW'(DEPTH));
        do_pop = fi.pop & (cnt != '0);
        next_wr_ptr = do_push ? bump(wr_ptr) : wr_ptr;
        next_rd_ptr = do_pop ? bump(rd_ptr) : rd_ptr;
        next_cnt = cnt + CW'(do_push) - CW'(do_pop);
        if (fi.clear) begin
            next_wr_ptr = '0;
            next_rd_ptr = '0;
            next_cnt = '0;
        end
    end

    // State and storage
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            cnt <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            cnt <= next_cnt;
        end
        if (do_push && !fi.clear) begin
            mem[wr_ptr] <= fi.wdata;
        end
    end

    assign fi.rdata = mem[rd_ptr];
    assign fi.count = cnt;
    assign fi.full = (cnt == CW'(DEPTH));
    assign fi.empty = (cnt == '0);
endmodule

// File: dioe_top.sv
// Digital I/O with set/clear outputs and timestamped edge FIFOs
module dioe_top (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [dioe_pkg::ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Digital channel pins
    input wire logic [dioe_pkg::NCH-1:0] digital_channel_i,
    output logic [dioe_pkg::NOUT-1:0] digital_channel_o,
    output logic [dioe_pkg::NOUT-1:0] digital_channel_oe_o
);
    import dioe_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    dioe_apb_st_t st, next_st;
    logic [31:0] rdata, next_rdata;
    logic err, next_err;
    logic [NGRP-1:0] dir, next_dir;
    logic filt_en, next_filt_en;
    logic [NOUT-1:0] out_q, next_out_q;
    logic [NOUT-1:0] oe_q;
    logic [LOW_W-1:0] set_lo, next_set_lo;
    logic [HIGH_W-1:0] set_hi, next_set_hi;
    logic [NFIFO-1:0] clr_q, next_clr_q;
    logic sync_q, next_sync_q;
    logic [1:0] phase, next_phase;
    logic [31:0] mon [NFIFO];
    logic [31:0] next_mon [NFIFO];
    logic [31:0] tmr [NFIFO];
    logic [31:0] next_tmr [NFIFO];
    logic [31:0] prev [NFIFO];
    logic [31:0] next_prev [NFIFO];
    logic [31:0] stamp [NFIFO];
    logic [31:0] next_stamp [NFIFO];

    // Combinational helpers
    logic [NCH-1:0] pin_s, inmask;
    logic [NOUT-1:0] outmask;
    logic [31:0] lvl [NFIFO];
    logic [31:0] imask [NFIFO];
    logic [NFIFO-1:0] push, pop, f_full, f_empty;
    logic [ENT_W-1:0] f_data [NFIFO];
    logic [CNT_W-1:0] f_cnt [NFIFO];
    logic acc, wr_acc, rd_acc, tick, is_fifo, fsel;
    logic [2:0] word;

    // ------------------------------------------------------------
    // Pin synchroniser and direction masks
    // ------------------------------------------------------------
    dioe_sync #(.W(NCH)) u_sync (
        .clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .d_i(digital_channel_i),
        .q_o(pin_s)
    );

    // Group bit 1 makes its eight channels outputs; group 5 holds only channels 40 and 41
    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            if (c < NOUT) begin
                outmask[c] = dir[c / GRP_SZ];
                inmask[c] = ~dir[c / GRP_SZ];
            end else begin
                inmask[c] = 1'b1;
            end
        end
    end

    // Per-FIFO channel slices
    always_comb begin
        lvl[0] = pin_s[LOW_W-1:0];
        imask[0] = inmask[LOW_W-1:0];
        lvl[1] = {3'h0, pin_s[NCH-1:LOW_W]};
        imask[1] = {3'h0, inmask[NCH-1:LOW_W]};
    end

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    always_comb begin
        acc = psel_i & penable_i & pready_o;
        wr_acc = acc & pwrite_i;
        rd_acc = acc & ~pwrite_i;
        is_fifo = (paddr_i[7:5] == WIN_FIFO1) || (paddr_i[7:5] == WIN_FIFO2);
        fsel = (paddr_i[7:5] == WIN_FIFO2);
        word = paddr_i[4:2];
        tick = ~filt_en | (phase == 2'h0);
    end

    // Answer one cycle into the access phase
    always_comb begin
        next_st = st;
        next_rdata = rdata;
        next_err = err;
        case (st)
            ST_IDLE: begin
                if (psel_i && penable_i) begin
                    next_st = ST_ACK;
                    next_rdata = 32'h0000_0000;
                    next_err = 1'b0;
                    if (paddr_i[1:0] != 2'h0) begin
                        next_err = 1'b1;
                    end else if (is_fifo) begin
                        case (word)
                            W_MON: next_rdata = mon[fsel];
                            W_FILL: next_rdata = 32'(f_cnt[fsel]);
                            W_POP_LVL: next_rdata = f_empty[fsel] ? 32'h0000_0000
                                : f_data[fsel][ENT_W-1:32];
                            W_POP_STAMP: next_rdata = stamp[fsel];
                            W_TIMER: next_rdata = tmr[fsel];
                            default: next_err = 1'b1;
                        endcase
                    end else begin
                        case (paddr_i)
                            ADDR_DIR: next_rdata = {23'h00_0000, filt_en, 2'h0, dir};
                            ADDR_LOW_SET: next_rdata = set_lo;
                            ADDR_LOW_CLR: next_rdata = 32'h0000_0000;
                            ADDR_LOW_RB: next_rdata = out_q[LOW_W-1:0];
                            ADDR_HIGH_SET: next_rdata = {22'h00_0000, set_hi};
                            ADDR_HIGH_CLR: next_rdata = 32'h0000_0000;
                            ADDR_HIGH_RB: next_rdata = {22'h00_0000, out_q[NOUT-1:LOW_W]};
                            ADDR_CMD: next_rdata = 32'h0000_0000;
                            default: next_err = 1'b1;
                        endcase
                    end
                end
            end
            ST_ACK: begin
                next_st = ST_IDLE;
                // Error flag only stands alongside ready
                next_err = 1'b0;
            end
            default: begin
                next_st = ST_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Register writes and output latch
    // ------------------------------------------------------------
    always_comb begin
        next_dir = dir;
        next_filt_en = filt_en;
        next_set_lo = set_lo;
        next_set_hi = set_hi;
        next_out_q = out_q;
        next_clr_q = '0;
        next_sync_q = 1'b0;
        for (int f = 0; f < NFIFO; f++) begin
            next_mon[f] = mon[f];
        end
        if (wr_acc && !err) begin
            if (is_fifo) begin
                if (word == W_MON) begin
                    next_mon[fsel] = fsel ? {3'h0, pwdata_i[F2_W-1:0]} : pwdata_i;
                end
            end else begin
                case (paddr_i)
                    ADDR_DIR: begin
                        next_dir = pwdata_i[NGRP-1:0];
                        next_filt_en = pwdata_i[FILT_BIT];
                    end
                    ADDR_LOW_SET: next_set_lo = pwdata_i;
                    ADDR_LOW_CLR: begin
                        // Clear applied last so it wins; inputs masked off
                        next_out_q[LOW_W-1:0] = (out_q[LOW_W-1:0]
                            | (set_lo & outmask[LOW_W-1:0]))
                            & ~(pwdata_i & outmask[LOW_W-1:0]);
                    end
                    ADDR_HIGH_SET: next_set_hi = pwdata_i[HIGH_W-1:0];
                    ADDR_HIGH_CLR: begin
                        next_out_q[NOUT-1:LOW_W] = (out_q[NOUT-1:LOW_W]
                            | (set_hi & outmask[NOUT-1:LOW_W]))
                            & ~(pwdata_i[HIGH_W-1:0] & outmask[NOUT-1:LOW_W]);
                    end
                    ADDR_CMD: begin
                        next_clr_q = {pwdata_i[CMD_CLR2], pwdata_i[CMD_CLR1]};
                        next_sync_q = pwdata_i[CMD_SYNC];
                    end
                    default: next_out_q = out_q;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Timers, filter phase, edge detection
    // ------------------------------------------------------------
    always_comb begin
        next_phase = (sync_q || phase == 2'(FILT_CYC - 1)) ? 2'h0 : phase + 2'h1;
        for (int f = 0; f < NFIFO; f++) begin
            next_tmr[f] = sync_q ? 32'h0000_0000 : tmr[f] + 32'h0000_0001;
            next_prev[f] = tick ? lvl[f] : prev[f];
            // Only watched input channels count
            push[f] = tick && (((lvl[f] ^ prev[f]) & mon[f] & imask[f]) != '0);
            pop[f] = rd_acc && !err && is_fifo && (word == W_POP_LVL)
                && (fsel == f[0]);
            next_stamp[f] = (pop[f] && !f_empty[f]) ? f_data[f][31:0] : stamp[f];
        end
    end

    // ------------------------------------------------------------
    // FIFOs
    // ------------------------------------------------------------
    dioe_fifo_if #(.W(ENT_W), .CW(CNT_W)) fif [NFIFO] ();

    generate
        for (genvar g = 0; g < NFIFO; g++) begin : g_fifo
            assign fif[g].push = push[g];
            assign fif[g].pop = pop[g];
            assign fif[g].clear = clr_q[g] | sync_q;
            assign fif[g].wdata = {lvl[g], tmr[g]};
            assign f_data[g] = fif[g].rdata;
            assign f_cnt[g] = fif[g].count;
            assign f_full[g] = fif[g].full;
            assign f_empty[g] = fif[g].empty;
            dioe_fifo #(.DEPTH(FIFO_DEPTH), .W(ENT_W)) u_fifo (
                .clk_i(ref_clk_i),
                .rst_n_i(rst_n_i),
                .fi(fif[g].store)
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            st <= ST_IDLE;
            rdata <= 32'h0000_0000;
            err <= 1'b0;
            dir <= DIR_RST;
            filt_en <= 1'b0;
            out_q <= OUT_RST;
            oe_q <= OUT_RST;
            set_lo <= 32'h0000_0000;
            set_hi <= 10'h000;
            clr_q <= '0;
            sync_q <= 1'b0;
            phase <= 2'h0;
            for (int f = 0; f < NFIFO; f++) begin
                mon[f] <= 32'h0000_0000;
                tmr[f] <= 32'h0000_0000;
                prev[f] <= 32'h0000_0000;
                stamp[f] <= 32'h0000_0000;
            end
        end else begin
            st <= next_st;
            rdata <= next_rdata;
            err <= next_err;
            dir <= next_dir;
            filt_en <= next_filt_en;
            out_q <= next_out_q;
            oe_q <= outmask;
            set_lo <= next_set_lo;
            set_hi <= next_set_hi;
            clr_q <= next_clr_q;
            sync_q <= next_sync_q;
            phase <= next_phase;
            for (int f = 0; f < NFIFO; f++) begin
                mon[f] <= next_mon[f];
                tmr[f] <= next_tmr[f];
                prev[f] <= next_prev[f];
                stamp[f] <= next_stamp[f];
            end
        end
    end

    // Outputs straight from flops
    assign prdata_o = rdata;
    assign pready_o = st[1];
    assign pslverr_o = err;
    assign digital_channel_o = out_q;
    assign digital_channel_oe_o = oe_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    logic lclr_acc, hclr_acc, sync_wr;
    assign lclr_acc = wr_acc && !err && (paddr_i == ADDR_LOW_CLR);
    assign hclr_acc = wr_acc && !err && (paddr_i == ADDR_HIGH_CLR);
    assign sync_wr = wr_acc && !err && (paddr_i == ADDR_CMD) && pwdata_i[CMD_SYNC];

    sequence s_sync_then_count;
        ##1 (tmr[0] == 32'h0000_0000) ##1 (tmr[0] == 32'h0000_0001);
    endsequence

    a_input_chan_hold: assert property (lclr_acc |=>
        ((digital_channel_o[31:0] ^ $past(digital_channel_o[31:0]))
        & ~$past(outmask[31:0])) == 32'h0000_0000)
        else $error("input channel changed by set/clear");
    a_clear_wins: assert property (lclr_acc |=>
        (digital_channel_o[31:0] & $past(pwdata_i & outmask[31:0])) == 32'h0000_0000)
        else $error("cleared output channel not low");
    a_high_idle_hold: assert property (hclr_acc && pwdata_i[9:0] == 10'h000
        && set_hi == 10'h000 |=> $stable(digital_channel_o))
        else $error("empty high bank command changed outputs");
    a_timer_sync_zero: assert property (sync_wr |=> s_sync_then_count)
        else $error("timer not zeroed by synchronize");
    a_timer_step_one: assert property (!sync_q |=> tmr[0] == $past(tmr[0]) + 32'h0000_0001)
        else $error("timer did not advance by one");
    a_full_keeps_count: assert property (f_full[0] && !pop[0] && !clr_q[0] && !sync_q
        |=> f_cnt[0] == CNT_W'(FIFO_DEPTH))
        else $error("full FIFO count changed");
    a_edge_push_count: assert property (push[0] && !f_full[0] && !pop[0]
        && !clr_q[0] && !sync_q |=> f_cnt[0] == $past(f_cnt[0]) + 9'h001)
        else $error("detected edge not stored");
    a_filter_spacing: assert property (push[0] && filt_en && !sync_q |=> filt_en |-> !push[0])
        else $error("filtered pushes too close");
    a_fill_bound: assert property (f_cnt[1] <= CNT_W'(FIFO_DEPTH))
        else $error("fill count above depth");
endmodule

// File: dioe_ttl_model.sv
// Far-side TTL lines that meet the digital channel pins
module dioe_ttl_model
    import dioe_pkg::*;
(
    // Line levels set by the bench
    input wire logic [dioe_pkg::NCH-1:0] ext_level_i,
    // Device drive and enables
    input wire logic [dioe_pkg::NOUT-1:0] drive_i,
    input wire logic [dioe_pkg::NOUT-1:0] drive_oe_i,
    // Resolved pin levels
    output logic [dioe_pkg::NCH-1:0] pin_o
);
    // Driven channels follow the device, the rest follow the line
    always_comb begin
        pin_o = ext_level_i;
        for (int i = 0; i < NOUT; i++) begin
            if (drive_oe_i[i]) begin
                pin_o[i] = drive_i[i];
            end
        end
    end
endmodule

// File: dioe_tb_top.sv
// Self-checking bench for the digital I/O edge timestamp block
module dioe_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import dioe_pkg::*;

    // ----------------------------------------
    // Signals and instances
    // ----------------------------------------
    logic ref_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [7:0] paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0000_0000;
    logic [31:0] prdata_o;
    logic pready_o;
    logic pslverr_o;
    logic [NCH-1:0] ext_level = '0;
    logic [NCH-1:0] pins;
    logic [NOUT-1:0] dout;
    logic [NOUT-1:0] doe;
    logic [31:0] rd;
    logic [31:0] t0;
    logic err;
    int bad_count = 0;
    int samples_checked = 0;

    dioe_top uut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .digital_channel_i(pins),
        .digital_channel_o(dout), .digital_channel_oe_o(doe));
    dioe_ttl_model line_model (.ext_level_i(ext_level), .drive_i(dout),
        .drive_oe_i(doe), .pin_o(pins));

    // ----------------------------------------
    // Bus, compare and stimulus tasks
    // ----------------------------------------
    function automatic logic [7:0] fa(input logic [2:0] win, input logic [2:0] w);
        return {win, w, 2'b00};
    endfunction

    // One APB transfer; waits for pready, the watchdog bounds the wait
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge ref_clk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge ref_clk_i);
        end while (pready_o !== 1'b1);
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Flip one external line, then let it settle
    task automatic tog(input int ch, input int gap);
        @(posedge ref_clk_i);
        ext_level[ch] <= ~ext_level[ch];
        repeat (gap) @(posedge ref_clk_i);
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Clock, watchdog and main sequence
    // ----------------------------------------
    initial begin
        forever #5 ref_clk_i = ~ref_clk_i;
    end

    // Cuts a hang well past the expected few thousand cycles
    initial begin
        repeat (20000) @(posedge ref_clk_i);
        bad_count++;
        print_verdict();
    end

    initial begin
        repeat (8) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        apb(1'b0, ADDR_LOW_RB, 32'h0);
        chk("rb reset", 32'h0000_0000, rd);
        apb(1'b1, ADDR_DIR, 32'h0000_0015);
        repeat (2) @(posedge ref_clk_i);
        chk("oe low", 32'h00FF_00FF, doe[31:0]);
        chk("oe high", 32'h0000_00FF, {22'h0, doe[41:32]});
        apb(1'b1, ADDR_LOW_SET, 32'hFFFF_FFFF);
        apb(1'b1, ADDR_LOW_CLR, 32'h0000_00F0);
        @(posedge ref_clk_i);
        chk("low out", 32'h00FF_000F, dout[31:0]);
        apb(1'b0, ADDR_LOW_RB, 32'h0);
        chk("low rb", 32'h00FF_000F, rd & 32'h00FF_00FF);
        apb(1'b1, ADDR_HIGH_SET, 32'hFFFF_FC05);
        apb(1'b1, ADDR_HIGH_CLR, 32'h0000_0001);
        @(posedge ref_clk_i);
        chk("high out", 32'h0000_0004, {22'h0, dout[41:32]});
        apb(1'b0, ADDR_HIGH_RB, 32'h0);
        chk("high rb", 32'h0000_0004, rd & 32'h0000_00FF);
        apb(1'b0, 8'h7C, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, err});
        apb(1'b0, 8'h05, 32'h0);
        chk("misaligned err", 32'h1, {31'h0, err});
        apb(1'b1, fa(WIN_FIFO1, W_MON), 32'hFFFF_FFFF);
        apb(1'b1, fa(WIN_FIFO2, W_MON), 32'h1FFF_FFFF);
        apb(1'b1, ADDR_CMD, 32'h0000_0003);
        apb(1'b1, ADDR_LOW_SET, 32'h0);
        apb(1'b1, ADDR_LOW_CLR, 32'h0000_0001);
        repeat (8) @(posedge ref_clk_i);
        apb(1'b0, fa(WIN_FIFO1, W_FILL), 32'h0);
        chk("fill output ch", 32'h0, rd);
        apb(1'b0, fa(WIN_FIFO1, W_TIMER), 32'h0);
        t0 = rd;
        apb(1'b0, fa(WIN_FIFO1, W_TIMER), 32'h0);
        chk("timer step", 32'h0000_0004, rd - t0);
        tog(8, 8);
        apb(1'b0, fa(WIN_FIFO1, W_FILL), 32'h0);
        chk("fill one", 32'h0000_0001, rd);
        apb(1'b0, fa(WIN_FIFO1, W_POP_LVL), 32'h0);
        chk("fifo1 level", 32'h00FF_010E, rd);
        apb(1'b0, fa(WIN_FIFO1, W_POP_STAMP), 32'h0);
        chk("stamp window", 32'h1, {31'h0, (rd - t0) > 4 && (rd - t0) < 16});
        tog(60, 8);
        apb(1'b0, fa(WIN_FIFO2, W_FILL), 32'h0);
        chk("fill fifo2", 32'h0000_0001, rd);
        apb(1'b0, fa(WIN_FIFO2, W_POP_LVL), 32'h0);
        chk("fifo2 level", 32'h1000_0004, rd);
        tog(60, 8);
        apb(1'b1, ADDR_CMD, 32'h0000_0004);
        apb(1'b0, fa(WIN_FIFO1, W_TIMER), 32'h0);
        chk("sync timer", 32'h1, {31'h0, rd < 8});
        apb(1'b0, fa(WIN_FIFO2, W_FILL), 32'h0);
        chk("sync fill", 32'h0, rd);
        for (int i = 0; i < 520; i++) tog(8, 3);
        apb(1'b0, fa(WIN_FIFO1, W_FILL), 32'h0);
        chk("fill full", 32'h0000_01FF, rd);
        apb(1'b0, fa(WIN_FIFO1, W_POP_LVL), 32'h0);
        chk("oldest level", 32'h00FF_000E, rd);
        apb(1'b0, fa(WIN_FIFO1, W_POP_LVL), 32'h0);
        chk("second level", 32'h00FF_010E, rd);
        apb(1'b1, ADDR_CMD, 32'h0000_0001);
        apb(1'b1, ADDR_DIR, 32'h0000_0115);
        // Odd spacing of five cycles, so only the filter keeps parity
        tog(8, 4);
        tog(8, 8);
        apb(1'b0, fa(WIN_FIFO1, W_FILL), 32'h0);
        chk("fill filtered", 32'h0000_0002, rd);
        apb(1'b0, fa(WIN_FIFO1, W_POP_LVL), 32'h0);
        apb(1'b0, fa(WIN_FIFO1, W_POP_STAMP), 32'h0);
        t0 = rd;
        apb(1'b0, fa(WIN_FIFO1, W_POP_LVL), 32'h0);
        apb(1'b0, fa(WIN_FIFO1, W_POP_STAMP), 32'h0);
        chk("stamp parity", 32'h0, (rd - t0) & 32'h0000_0001);
        apb(1'b1, ADDR_HIGH_SET, 32'h0);
        apb(1'b1, ADDR_HIGH_CLR, 32'h0);
        @(posedge ref_clk_i);
        chk("high hold", 32'h0000_0004, {22'h0, dout[41:32]});
        print_verdict();
    end
endmodule
